// ===== rtl/lts_pkg.sv
// Shared constants, types and register map of the lamp test sequencer
package lts_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int NUM_LAMPS = 62;
	localparam int NUM_OPERANDS = 8;
	localparam int SEL_W = 3;
	localparam int IDX_W = 6;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int IRQ_W = 4;

	// ------------------------------------------------------------
	// Timing: clock rate and millisecond time base
	// ------------------------------------------------------------
	localparam int CLOCK_HZ = 20_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
	localparam int QUAL_MS = 250;
	localparam int STAGE1_MS = 60_000;
	localparam int STEP_MS = 1000;
	localparam int QUAL_TICKS = QUAL_MS / TICK_MS;
	localparam int STAGE1_TICKS = STAGE1_MS / TICK_MS;
	localparam int STEP_TICKS = STEP_MS / TICK_MS;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATE = 4'h1;
	localparam logic [ADDR_W-1:0] REG_INT_STAT = 4'h2;
	localparam logic [ADDR_W-1:0] REG_INT_MASK = 4'h3;
	localparam logic [ADDR_W-1:0] REG_LAMP_IDX = 4'h4;
	localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
	localparam logic [IRQ_W-1:0] INT_MASK_RESET = 4'h0;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_STAGE1 = 4'h2,
		ST_STAGE2 = 4'h4,
		ST_STAGE3 = 4'h8
	} lts_state_type;

	typedef struct packed {
		logic [SEL_W-1:0] trigger_select;
		logic enable;
	} lts_ctrl_type;

	typedef struct packed {
		logic timeout;
		logic aborted;
		logic completed;
		logic started;
	} lts_event_type;

endpackage

// ===== rtl/lts_qualify.sv
// Pulse qualifier: a level change counts only once held long enough
`timescale 1ns/10ps
`default_nettype none
module lts_qualify #(
	parameter int QUAL_TICKS = lts_pkg::QUAL_TICKS
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Time base and raw operand
	input wire logic tick,
	input wire logic raw,
	// Qualified level
	output logic level
);
	logic [lts_pkg::CNT_W-1:0] held;

	always_ff @(posedge clock) begin
		if (srst) begin
			held <= '0;
			level <= 1'b0;
		end else if (raw == level) begin
			held <= '0;
		end else if (tick) begin
			if (held == lts_pkg::CNT_W'(QUAL_TICKS - 1)) begin
				level <= raw;
				held <= '0;
			end else begin
				held <= held + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== rtl/lts_sequencer.sv
// Three-stage front-panel lamp test sequencer with register port
//
// Functional notes
// - Enabled test starts from selected operand
// - Test drives every lamp, pushbutton lamps too
// - Stage one lights all lamps while held
// - One minute held in stage one ends test
// - Release in stage one starts stage two
// - Stage two lights each lamp one second
// - Walk runs down columns, top left first
// - Stage two end enters stage three automatically
// - Stage three darkens each lamp one second
// - New rising edge aborts stage two or three
// - Both level and rising edge steer test
// - Operand pulses under 250 ms ignored
// - Test drives lamps, normal requests still stored
// - Test end shows stored lamp states at once
// - Reset key clears no targets during test
// - Active flag high from start until end
// - One started event pulse at test start
`timescale 1ns/10ps
`default_nettype none
module lts_sequencer #(
	parameter int TICK_CYCLES = lts_pkg::TICK_CYCLES,
	parameter int QUAL_TICKS = lts_pkg::QUAL_TICKS,
	parameter int STAGE1_TICKS = lts_pkg::STAGE1_TICKS,
	parameter int STEP_TICKS = lts_pkg::STEP_TICKS,
	parameter int NUM_LAMPS = lts_pkg::NUM_LAMPS
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Relay logic inputs
	input wire logic [lts_pkg::NUM_OPERANDS-1:0] operands,
	input wire logic [NUM_LAMPS-1:0] normal_lamps,
	input wire logic reset_key,
	// Register port
	input wire logic [lts_pkg::ADDR_W-1:0] addr,
	input wire logic [lts_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [lts_pkg::DATA_W-1:0] rd_data,
	// Panel and status outputs
	output logic [NUM_LAMPS-1:0] lamp_out,
	output logic lamp_check_active_flag,
	output logic lamp_check_started_event,
	output logic target_clear,
	output logic irq
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	lts_pkg::lts_ctrl_type ctrl;
	lts_pkg::lts_state_type state;
	lts_pkg::lts_state_type next_state;
	lts_pkg::lts_event_type next_event;
	logic [lts_pkg::IRQ_W-1:0] int_stat;
	logic [lts_pkg::IRQ_W-1:0] int_mask;
	logic [lts_pkg::CNT_W-1:0] ms_cnt;
	logic [lts_pkg::IDX_W-1:0] lamp_idx;
	logic [NUM_LAMPS-1:0] lamp_memory;
	logic [NUM_LAMPS-1:0] next_lamps;
	logic tick;
	logic trigger_raw;
	logic qual_level;
	logic qual_prev;
	logic qual_rise;
	logic qual_fall;
	logic step_done;
	logic last_lamp;
	logic stage1_limit;

	// ------------------------------------------------------------
	// Time base and operand qualification
	// ------------------------------------------------------------
	lts_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clock(clock),
		.srst(srst),
		.tick(tick)
	);

	assign trigger_raw = operands[ctrl.trigger_select];

	lts_qualify #(
		.QUAL_TICKS(QUAL_TICKS)
	) u_qualify (
		.clock(clock),
		.srst(srst),
		.tick(tick),
		.raw(trigger_raw),
		.level(qual_level)
	);

	always_ff @(posedge clock) begin
		if (srst) begin
			qual_prev <= 1'b0;
		end else begin
			qual_prev <= qual_level;
		end
	end

	assign qual_rise = qual_level & ~qual_prev;
	assign qual_fall = ~qual_level & qual_prev;
	// Step timer runs only in the walks, or it would keep resetting the stage one limit
	assign step_done = tick && (ms_cnt == lts_pkg::CNT_W'(STEP_TICKS - 1))
		&& (state == lts_pkg::ST_STAGE2 || state == lts_pkg::ST_STAGE3);
	assign stage1_limit = tick && (ms_cnt == lts_pkg::CNT_W'(STAGE1_TICKS - 1));
	assign last_lamp = (lamp_idx == lts_pkg::IDX_W'(NUM_LAMPS - 1));

	// ------------------------------------------------------------
	// Sequence control
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_event = '0;
		case (state)
			lts_pkg::ST_IDLE: begin
				if (ctrl.enable && qual_rise) begin
					next_state = lts_pkg::ST_STAGE1;
					next_event.started = 1'b1;
				end
			end
			lts_pkg::ST_STAGE1: begin
				if (stage1_limit) begin
					next_state = lts_pkg::ST_IDLE;
					next_event.timeout = 1'b1;
				end else if (qual_fall) begin
					next_state = lts_pkg::ST_STAGE2;
				end
			end
			lts_pkg::ST_STAGE2: begin
				if (qual_rise) begin
					next_state = lts_pkg::ST_IDLE;
					next_event.aborted = 1'b1;
				end else if (step_done && last_lamp) begin
					next_state = lts_pkg::ST_STAGE3;
				end
			end
			lts_pkg::ST_STAGE3: begin
				if (qual_rise) begin
					next_state = lts_pkg::ST_IDLE;
					next_event.aborted = 1'b1;
				end else if (step_done && last_lamp) begin
					next_state = lts_pkg::ST_IDLE;
					next_event.completed = 1'b1;
				end
			end
			default: begin
				next_state = lts_pkg::ST_IDLE;
			end
		endcase
		if (!ctrl.enable && state != lts_pkg::ST_IDLE) begin
			next_state = lts_pkg::ST_IDLE;
			next_event = '0;
			next_event.aborted = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state <= lts_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Millisecond counter restarts on each state change and step
	always_ff @(posedge clock) begin
		if (srst || next_state != state || step_done) begin
			ms_cnt <= '0;
		end else if (tick) begin
			ms_cnt <= ms_cnt + 1'b1;
		end
	end

	// lamp vector is in column scan order, index 0 top left
	always_ff @(posedge clock) begin
		if (srst || next_state != state) begin
			lamp_idx <= '0;
		end else if (step_done && !last_lamp) begin
			lamp_idx <= lamp_idx + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Lamp drive
	// ------------------------------------------------------------
	// normal requests stored throughout the test
	always_ff @(posedge clock) begin
		if (srst) begin
			lamp_memory <= '0;
		end else begin
			lamp_memory <= normal_lamps;
		end
	end

	for (genvar g = 0; g < NUM_LAMPS; g++) begin : g_lamp
		always_comb begin
			case (state)
				lts_pkg::ST_STAGE1: next_lamps[g] = 1'b1;
				lts_pkg::ST_STAGE2: next_lamps[g] = (lamp_idx == lts_pkg::IDX_W'(g));
				lts_pkg::ST_STAGE3: next_lamps[g] = (lamp_idx != lts_pkg::IDX_W'(g));
				default: next_lamps[g] = lamp_memory[g];
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			lamp_out <= '0;
		end else begin
			lamp_out <= next_lamps;
		end
	end

	// ------------------------------------------------------------
	// Status outputs
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			lamp_check_active_flag <= 1'b0;
			lamp_check_started_event <= 1'b0;
			target_clear <= 1'b0;
		end else begin
			lamp_check_active_flag <= (state != lts_pkg::ST_IDLE);
			lamp_check_started_event <= next_event.started;
			target_clear <= reset_key && (state == lts_pkg::ST_IDLE)
				&& (next_state == lts_pkg::ST_IDLE);
		end
	end

	// ------------------------------------------------------------
	// Register port and interrupt
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl <= lts_pkg::lts_ctrl_type'(lts_pkg::CTRL_RESET[lts_pkg::SEL_W:0]);
			int_mask <= lts_pkg::INT_MASK_RESET;
		end else if (wr_en) begin
			if (addr == lts_pkg::REG_CTRL) begin
				ctrl <= lts_pkg::lts_ctrl_type'(wr_data[lts_pkg::SEL_W:0]);
			end
			if (addr == lts_pkg::REG_INT_MASK) begin
				int_mask <= wr_data[lts_pkg::IRQ_W-1:0];
			end
		end
	end

	// Write one to clear; a new event in the same cycle wins
	always_ff @(posedge clock) begin
		if (srst) begin
			int_stat <= '0;
		end else if (wr_en && addr == lts_pkg::REG_INT_STAT) begin
			int_stat <= (int_stat & ~wr_data[lts_pkg::IRQ_W-1:0]) | next_event;
		end else begin
			int_stat <= int_stat | next_event;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_stat & int_mask);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rd_data <= '0;
		end else if (rd_en) begin
			case (addr)
				lts_pkg::REG_CTRL: rd_data <= lts_pkg::DATA_W'(ctrl);
				lts_pkg::REG_STATE: rd_data <= lts_pkg::DATA_W'(state);
				lts_pkg::REG_INT_STAT: rd_data <= lts_pkg::DATA_W'(int_stat);
				lts_pkg::REG_INT_MASK: rd_data <= lts_pkg::DATA_W'(int_mask);
				lts_pkg::REG_LAMP_IDX: rd_data <= lts_pkg::DATA_W'(lamp_idx);
				default: rd_data <= '0;
			endcase
		end else begin
			rd_data <= '0;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	a_stage1_all_on: assert property (
		state == lts_pkg::ST_STAGE1 |=> lamp_out == {NUM_LAMPS{1'b1}}
	) else $error("stage one lamps not all lit");

	a_stage2_one_lit: assert property (
		state == lts_pkg::ST_STAGE2 |=> $onehot(lamp_out)
	) else $error("stage two not exactly one lamp lit");

	a_stage3_one_dark: assert property (
		state == lts_pkg::ST_STAGE3 |=> $onehot(~lamp_out)
	) else $error("stage three not exactly one lamp dark");

	a_release_walk: assert property (
		state == lts_pkg::ST_STAGE1 && !stage1_limit && qual_fall && ctrl.enable
		|=> state == lts_pkg::ST_STAGE2 ##1 lamp_out[0]
	) else $error("release did not start walk at first lamp");

	a_edge_abort: assert property (
		(state == lts_pkg::ST_STAGE2 || state == lts_pkg::ST_STAGE3) && qual_rise
		|=> state == lts_pkg::ST_IDLE ##1 !lamp_check_active_flag
	) else $error("rising edge did not abort test");

	a_start_event: assert property (
		$rose(lamp_check_active_flag) |-> $past(lamp_check_started_event)
		&& !lamp_check_started_event
	) else $error("start event not paired with active flag");

	a_idle_restore: assert property (
		state == lts_pkg::ST_IDLE && $past(state) == lts_pkg::ST_IDLE
		|=> lamp_out == $past(normal_lamps, 2)
	) else $error("idle lamps not the stored requests");

	a_key_blocked: assert property (
		state != lts_pkg::ST_IDLE |=> !target_clear
	) else $error("target clear during test");

	a_disabled_idle: assert property (
		!ctrl.enable && state == lts_pkg::ST_IDLE |=> state == lts_pkg::ST_IDLE
	) else $error("disabled feature started a test");

	a_irq_level: assert property (
		irq == |($past(int_stat) & $past(int_mask))
	) else $error("interrupt not following masked status");

	c_stage2: cover property (state == lts_pkg::ST_STAGE1 ##1 state == lts_pkg::ST_STAGE2);
	c_stage3: cover property (state == lts_pkg::ST_STAGE2 ##1 state == lts_pkg::ST_STAGE3);
	c_timeout: cover property (next_event.timeout);
	c_complete: cover property (next_event.completed);
endmodule
`default_nettype wire

// ===== rtl/lts_tick.sv
// Millisecond time base: one-cycle enable pulse from a divider
`timescale 1ns/10ps
`default_nettype none
module lts_tick #(
	parameter int TICK_CYCLES = lts_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Time base
	output logic tick
);
	localparam int W = $clog2(TICK_CYCLES + 1);
	logic [W-1:0] count;

	always_ff @(posedge clock) begin
		if (srst) begin
			count <= '0;
			tick <= 1'b0;
		end else if (count == W'(TICK_CYCLES - 1)) begin
			count <= '0;
			tick <= 1'b1;
		end else begin
			count <= count + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== verif/lts_operand_model.sv
// Relay-side partner: turns one push request into the operand bus
`timescale 1ns/10ps
`default_nettype none
module lts_operand_model (
	// Push request and chosen operand
	input wire logic press,
	input wire logic [lts_pkg::SEL_W-1:0] sel,
	// Operand bus
	output logic [lts_pkg::NUM_OPERANDS-1:0] operands
);
	// ------------------------------------------------------------
	// Operand drive
	// ------------------------------------------------------------
	// pulses held by bench
	// Unselected operands sit opposite, so a wrong select starts a test early
	always_comb begin
		operands = {lts_pkg::NUM_OPERANDS{~press}};
		operands[sel] = press;
	end
endmodule
`default_nettype wire

// ===== verif/lts_sequencer_tb_top.sv
// Self-checking bench of the lamp test sequencer
`timescale 1ns/10ps
`default_nettype none
module lts_sequencer_tb_top;
	localparam int NL = lts_pkg::NUM_LAMPS;
	localparam logic [NL-1:0] PAT_A = 62'h2AAAAAAAAAAAAAAA;
	localparam logic [NL-1:0] PAT_B = 62'h1555555555555555;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic press = 1'b0;
	logic [lts_pkg::SEL_W-1:0] sel = 3'h5;
	logic [lts_pkg::NUM_OPERANDS-1:0] operands;
	logic [NL-1:0] normal_lamps = '0;
	logic reset_key = 1'b0;
	logic [lts_pkg::ADDR_W-1:0] addr = '0;
	logic [lts_pkg::DATA_W-1:0] wr_data = '0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [lts_pkg::DATA_W-1:0] rd_data;
	logic [NL-1:0] lamp_out;
	logic active, started, target_clear, irq;
	int fail_count = 0;
	int checks = 0;
	int starts = 0;

	// ------------------------------------------------------------
	// Design, partner, clock
	// ------------------------------------------------------------
	// Short counts keep each walk near five hundred cycles
	lts_sequencer #(.TICK_CYCLES(4), .QUAL_TICKS(3), .STAGE1_TICKS(20), .STEP_TICKS(2),
		.NUM_LAMPS(NL)) i_lts_sequencer (.clock(clock), .srst(srst), .operands(operands),
		.normal_lamps(normal_lamps), .reset_key(reset_key), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .lamp_out(lamp_out),
		.lamp_check_active_flag(active), .lamp_check_started_event(started),
		.target_clear(target_clear), .irq(irq));
	lts_operand_model i_lts_operand_model (.press(press), .sel(sel), .operands(operands));

	initial begin
		forever #25 clock = ~clock;
	end

	always @(posedge clock) begin
		if (started === 1'b1) starts++;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1;
		check(rd_data, e);
	endtask

	task automatic drive(input logic p, input logic k);
		@(posedge clock);
		press <= p;
		reset_key <= k;
	endtask

	task automatic wait_active(input logic v, input int lim);
		for (int i = 0; i < lim && active !== v; i++) begin
			cyc(1);
		end
		check(active, v);
	endtask

	// Expected lamp k alone lit, or alone dark when inverted
	task automatic walk(input logic inv);
		logic [NL-1:0] e;
		for (int k = 0; k < NL; k++) begin
			e = {{(NL-1){1'b0}}, 1'b1} << k;
			if (inv) begin
				e = ~e;
			end
			for (int i = 0; i < 40 && lamp_out !== e; i++) begin
				cyc(1);
			end
			check(lamp_out, e);
		end
	endtask

	task automatic wrap_up;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		rd_chk(lts_pkg::REG_CTRL, 8'h00);
		rd_chk(lts_pkg::REG_STATE, 8'h01);
		rd_chk(lts_pkg::REG_INT_MASK, 8'h00);
		rd_chk(lts_pkg::REG_INT_STAT, 8'h00);
		rd_chk(4'hF, 8'h00);
		check(irq, 1'b0);
		$display("test reset done");
	endtask

	task automatic t_disabled;
		@(posedge clock);
		normal_lamps <= PAT_A;
		drive(1'b1, 1'b1);
		cyc(40);
		check(active, 1'b0);
		check(lamp_out, PAT_A);
		check(target_clear, 1'b1);
		drive(1'b0, 1'b0);
		cyc(30);
		$display("test disabled done");
	endtask

	task automatic t_full;
		wr(lts_pkg::REG_INT_STAT, 8'h0F);
		wr(lts_pkg::REG_CTRL, 8'h0B);
		cyc(30);
		check(active, 1'b0);
		drive(1'b1, 1'b0);
		wait_active(1'b1, 100);
		cyc(2);
		check(starts, 1);
		check(lamp_out, {NL{1'b1}});
		rd_chk(lts_pkg::REG_STATE, 8'h02);
		drive(1'b1, 1'b1);
		normal_lamps <= PAT_B;
		cyc(5);
		check(target_clear, 1'b0);
		drive(1'b0, 1'b0);
		walk(1'b0);
		walk(1'b1);
		wait_active(1'b0, 60);
		cyc(2);
		check(lamp_out, PAT_B);
		rd_chk(lts_pkg::REG_STATE, 8'h01);
		rd_chk(lts_pkg::REG_INT_STAT, 8'h03);
		check(irq, 1'b0);
		wr(lts_pkg::REG_INT_MASK, 8'h02);
		cyc(3);
		check(irq, 1'b1);
		wr(lts_pkg::REG_INT_STAT, 8'h03);
		cyc(3);
		check(irq, 1'b0);
		$display("test full done");
	endtask

	task automatic t_timeout;
		wr(lts_pkg::REG_INT_STAT, 8'h0F);
		drive(1'b1, 1'b0);
		wait_active(1'b1, 100);
		wait_active(1'b0, 200);
		rd_chk(lts_pkg::REG_INT_STAT, 8'h09);
		rd_chk(lts_pkg::REG_STATE, 8'h01);
		drive(1'b0, 1'b0);
		cyc(30);
		check(active, 1'b0);
		$display("test timeout done");
	endtask

	task automatic t_abort;
		wr(lts_pkg::REG_INT_STAT, 8'h0F);
		drive(1'b1, 1'b0);
		wait_active(1'b1, 100);
		cyc(20);
		drive(1'b0, 1'b0);
		for (int i = 0; i < 60 && lamp_out !== 62'h1; i++) begin
			cyc(1);
		end
		check(lamp_out, 62'h1);
		rd_chk(lts_pkg::REG_LAMP_IDX, 8'h00);
		// One-cycle pulse stays well under the qualify time
		drive(1'b1, 1'b0);
		drive(1'b0, 1'b0);
		cyc(30);
		rd_chk(lts_pkg::REG_STATE, 8'h04);
		drive(1'b1, 1'b0);
		wait_active(1'b0, 100);
		rd_chk(lts_pkg::REG_INT_STAT, 8'h05);
		drive(1'b0, 1'b0);
		cyc(30);
		$display("test abort done");
	endtask

	// ------------------------------------------------------------
	// Sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clock);
		srst <= 1'b0;
		t_reset();
		t_disabled();
		t_full();
		t_timeout();
		t_abort();
		check(starts, 3);
		wrap_up();
	end

	// Whole run needs about 1500 cycles
	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
